//--- verilog/etm_pkg.sv
`default_nettype none
package etm_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int SOFT_W = 8;
    localparam int PRESC_W = 7;
    localparam int SLOT_W = 5;
    localparam int IRQ_W = 3;

    // register map, byte addresses above the 1 KB window
    localparam logic [11:0] OFF_EVT = 12'h400;
    localparam logic [11:0] OFF_EVT_CLR = 12'h404;
    localparam logic [11:0] OFF_EVT_IDX = 12'h408;
    localparam logic [11:0] OFF_MBX_EVT = 12'h40c;
    localparam logic [11:0] OFF_TIMER = 12'h410;
    localparam logic [11:0] OFF_SCHED = 12'h414;
    localparam logic [11:0] OFF_PRESC = 12'h418;
    localparam logic [11:0] OFF_CTRL = 12'h41c;
    localparam logic [11:0] OFF_IRQ_STAT = 12'h420;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h424;

    // field positions
    localparam int EVT_TIMER_BIT = 31;
    localparam int EVT_MBX_BIT = 30;
    localparam int IDX_VALID_BIT = 31;
    localparam int CTRL_HOST_INT_BIT = 0;
    localparam int IRQ_TIMER_BIT = 0;
    localparam int IRQ_MBX_BIT = 1;
    localparam int IRQ_MBX0_BIT = 2;

    // reset values
    localparam logic [31:0] TIMER_RST = 32'h0000_0000;
    localparam logic [31:0] SCHED_RST = 32'h0000_0000;
    localparam logic [6:0] PRESC_RST = 7'h00;
    localparam logic [2:0] IRQ_MASK_RST = 3'h0;

    // timer ticks behind the count that still fire: one minute of 1 us ticks
    localparam logic [31:0] LATE_WIN = 32'h0393_8700;

    typedef enum logic [0:0] {
        ETM_IDLE = 1'b0,
        ETM_ARMED = 1'b1
    } etm_sched_type;

    function automatic logic in_window(input logic [11:0] a);
        return a[11:10] == 2'h0;
    endfunction

    function automatic logic is_mbx_hi(input logic [11:0] a);
        return (a[11:8] == 4'h1) && a[2];
    endfunction

    function automatic logic is_mbx0(input logic [11:0] a);
        return a[11:3] == 9'h020;
    endfunction
endpackage
`default_nettype wire

//--- verilog/etm_prio.sv
`timescale 1ns/100ps
`default_nettype none
module etm_prio (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // events in
    input wire logic [31:0] i_evt,
    // jump-table index out
    output logic [4:0] o_idx,
    output logic o_valid
);
    logic [4:0] idx_next;

    // later iterations overwrite, so the highest set bit wins
    always_comb begin
        idx_next = 5'h00;
        for (int i = 0; i < 32; i++) begin
            if (i_evt[i]) begin
                idx_next = 5'(i);
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_idx <= 5'h00;
            o_valid <= 1'b0;
        end else begin
            o_idx <= idx_next;
            o_valid <= |i_evt;
        end
    end

    a_prio_pick: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_valid |-> (($past(i_evt) >> o_idx) == 32'h1))
        else $error("index is not the highest pending event");
endmodule // etm_prio
`default_nettype wire

//--- verilog/etm_timer.sv
`timescale 1ns/100ps
`default_nettype none
module etm_timer (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // control
    input wire logic [6:0] i_presc,
    input wire logic i_count_wr,
    input wire logic [31:0] i_count_wdata,
    input wire logic i_sched_wr,
    input wire logic [31:0] i_sched_wdata,
    // status
    output logic [31:0] o_count,
    output logic [31:0] o_sched,
    output logic o_fire
);
    logic [6:0] pre_reg;
    logic tick;
    logic late;
    etm_pkg::etm_sched_type state_reg;

    // prescale value n gives one tick every n+1 clocks; greater-or-equal so that
    // lowering the prescale never leaves the divider above it for a full wrap
    assign tick = (pre_reg >= i_presc);
    // unsigned distance also catches a time that has just passed
    assign late = (o_count - o_sched) < etm_pkg::LATE_WIN;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pre_reg <= 7'h00;
        end else if (tick) begin
            pre_reg <= 7'h00;
        end else begin
            pre_reg <= pre_reg + 7'h01;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_count <= etm_pkg::TIMER_RST;
        end else if (i_count_wr) begin
            o_count <= i_count_wdata;
        end else if (tick) begin
            o_count <= o_count + 32'h1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sched <= etm_pkg::SCHED_RST;
        end else if (i_sched_wr) begin
            o_sched <= i_sched_wdata;
        end
    end

    // one event per programming, so a passed time does not refire forever
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= etm_pkg::ETM_IDLE;
            o_fire <= 1'b0;
        end else begin
            o_fire <= 1'b0;
            case (state_reg)
                etm_pkg::ETM_IDLE: begin
                    if (i_sched_wr) begin
                        state_reg <= etm_pkg::ETM_ARMED;
                    end
                end
                etm_pkg::ETM_ARMED: begin
                    if (i_sched_wr) begin
                        state_reg <= etm_pkg::ETM_ARMED;
                    end else if (late) begin
                        state_reg <= etm_pkg::ETM_IDLE;
                        o_fire <= 1'b1;
                    end
                end
                default: begin
                    state_reg <= etm_pkg::ETM_IDLE;
                end
            endcase
        end
    end

    a_tick_advance: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (tick && !i_count_wr) |=> (o_count == $past(o_count) + 32'h1))
        else $error("timer did not advance on a tick");
    a_fire_late: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state_reg == etm_pkg::ETM_ARMED && late && !i_sched_wr) |=> o_fire)
        else $error("armed timer reached its time without firing");
    a_fire_armed: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_fire |-> ($past(state_reg) == etm_pkg::ETM_ARMED) && state_reg == etm_pkg::ETM_IDLE)
        else $error("timer fired while not armed");
endmodule // etm_timer
`default_nettype wire

//--- verilog/etm_event_timer_mailbox.sv
`timescale 1ns/100ps
`default_nettype none
//Behaviour
// - one 32-bit event word, one bit per event to service
// - index register gives the highest set event bit, high bits first
// - some event bits are set and cleared by software writes only
// - 32-bit timer advances once per prescale period of 1 to 128 clocks
// - timer event raised when the count reaches the scheduled time
// - timer event also raised when the scheduled time lies recently behind
// - 1 KB window readable and writable by host and processors
// - second 256-byte quarter is 32 mailbox slots of 8 bytes
// - write to a slot's upper four bytes raises an event naming the slot
// - every mailbox slot has its own event bit
// - first 256 and last 512 bytes are plain storage, no events
// - reading a slot never changes its contents
// - writing the first slot releases the host interrupt on the next clock, two clocks after a host write
// - all registers reachable from both processor and host ports
// - host interrupt is level, active low, open drain
module etm_event_timer_mailbox (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // processor register port
    input wire logic [11:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // host target port
    input wire logic [11:0] i_host_addr,
    input wire logic [31:0] i_host_wdata,
    input wire logic i_host_wr,
    input wire logic i_host_rd,
    output logic [31:0] o_host_rdata,
    // interrupts
    output logic o_irq,
    output logic o_host_int_o,
    output logic o_host_int_oe_n
);
    logic [31:0] mem [0:255];
    logic h_wr_reg;
    logic [11:0] h_addr_reg;
    logic [31:0] h_wdata_reg;
    logic [7:0] soft_reg;
    logic timer_evt_reg;
    logic [31:0] mbx_evt_reg;
    logic [6:0] presc_reg;
    logic [2:0] irq_stat_reg;
    logic [2:0] irq_mask_reg;
    logic [31:0] evt_word;
    logic [31:0] mbx_set;
    logic mbx0_wr;
    logic [2:0] irq_ev;
    logic [32:0] w_evt;
    logic [32:0] w_clr;
    logic [32:0] w_mbx;
    logic [32:0] w_timer;
    logic [32:0] w_sched;
    logic [32:0] w_presc;
    logic [32:0] w_ctrl;
    logic [32:0] w_stat;
    logic [32:0] w_mask;
    logic [31:0] count;
    logic [31:0] sched;
    logic fire;
    logic [4:0] evt_idx;
    logic evt_valid;

    // processor wins when both ports write the same register in one cycle
    function automatic logic [32:0] pick(input logic [11:0] off);
        if (i_wr && i_addr == off) begin
            return {1'b1, i_wdata};
        end else if (h_wr_reg && h_addr_reg == off) begin
            return {1'b1, h_wdata_reg};
        end else begin
            return {1'b0, 32'h0};
        end
    endfunction

    function automatic logic [31:0] slot_hit(input logic wr, input logic [11:0] a);
        if (wr && etm_pkg::is_mbx_hi(a)) begin
            return 32'h1 << a[7:3];
        end else begin
            return 32'h0;
        end
    endfunction

    // reads have no side effect anywhere, so slots may be reread freely
    function automatic logic [31:0] rd_mux(input logic [11:0] a);
        logic [31:0] d;
        d = 32'h0;
        if (etm_pkg::in_window(a)) begin
            d = mem[a[9:2]];
        end else if (a == etm_pkg::OFF_EVT) begin
            d = evt_word;
        end else if (a == etm_pkg::OFF_EVT_IDX) begin
            d = {evt_valid, 26'h0, evt_idx};
        end else if (a == etm_pkg::OFF_MBX_EVT) begin
            d = mbx_evt_reg;
        end else if (a == etm_pkg::OFF_TIMER) begin
            d = count;
        end else if (a == etm_pkg::OFF_SCHED) begin
            d = sched;
        end else if (a == etm_pkg::OFF_PRESC) begin
            d = {25'h0, presc_reg};
        end else if (a == etm_pkg::OFF_CTRL) begin
            d = {31'h0, ~o_host_int_oe_n};
        end else if (a == etm_pkg::OFF_IRQ_STAT) begin
            d = {29'h0, irq_stat_reg};
        end else if (a == etm_pkg::OFF_IRQ_MASK) begin
            d = {29'h0, irq_mask_reg};
        end
        return d;
    endfunction

    // a process rather than assigns: the port strobes are read inside pick, not passed to it
    always_comb begin
        w_evt = pick(etm_pkg::OFF_EVT);
        w_clr = pick(etm_pkg::OFF_EVT_CLR);
        w_mbx = pick(etm_pkg::OFF_MBX_EVT);
        w_timer = pick(etm_pkg::OFF_TIMER);
        w_sched = pick(etm_pkg::OFF_SCHED);
        w_presc = pick(etm_pkg::OFF_PRESC);
        w_ctrl = pick(etm_pkg::OFF_CTRL);
        w_stat = pick(etm_pkg::OFF_IRQ_STAT);
        w_mask = pick(etm_pkg::OFF_IRQ_MASK);
    end

    assign mbx_set = slot_hit(i_wr, i_addr) | slot_hit(h_wr_reg, h_addr_reg);
    assign mbx0_wr = (i_wr && etm_pkg::is_mbx0(i_addr)) || (h_wr_reg && etm_pkg::is_mbx0(h_addr_reg));
    assign evt_word = {timer_evt_reg, |mbx_evt_reg, 22'h0, soft_reg};
    assign irq_ev = {mbx0_wr, |mbx_set, fire};
    assign o_host_int_o = 1'b0;

    // host write strobe, address and data are retimed once so they act on local-clock edges only
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            h_wr_reg <= 1'b0;
            h_addr_reg <= 12'h000;
            h_wdata_reg <= 32'h0;
        end else begin
            h_wr_reg <= i_host_wr;
            h_addr_reg <= i_host_addr;
            h_wdata_reg <= i_host_wdata;
        end
    end

    // window storage, host write first so a same-word processor write wins
    always_ff @(posedge i_clk) begin
        if (h_wr_reg && etm_pkg::in_window(h_addr_reg)) begin
            mem[h_addr_reg[9:2]] <= h_wdata_reg;
        end
        if (i_wr && etm_pkg::in_window(i_addr)) begin
            mem[i_addr[9:2]] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            soft_reg <= 8'h00;
        end else if (w_evt[32]) begin
            soft_reg <= w_evt[7:0];
        end else if (w_clr[32]) begin
            soft_reg <= soft_reg & ~w_clr[7:0];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            timer_evt_reg <= 1'b0;
        end else begin
            timer_evt_reg <= (timer_evt_reg & ~(w_clr[32] & w_clr[etm_pkg::EVT_TIMER_BIT])) | fire;
        end
    end

    // a set in the same cycle as its clear survives
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mbx_evt_reg <= 32'h0;
        end else begin
            mbx_evt_reg <= (mbx_evt_reg & ~(w_mbx[32] ? w_mbx[31:0] : 32'h0)) | mbx_set;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            presc_reg <= etm_pkg::PRESC_RST;
        end else if (w_presc[32]) begin
            presc_reg <= w_presc[6:0];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_stat_reg <= 3'h0;
            irq_mask_reg <= etm_pkg::IRQ_MASK_RST;
            o_irq <= 1'b0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~(w_stat[32] ? w_stat[2:0] : 3'h0)) | irq_ev;
            if (w_mask[32]) begin
                irq_mask_reg <= w_mask[2:0];
            end
            o_irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // releasing via the first slot wins over a set in the same cycle
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_host_int_oe_n <= 1'b1;
        end else if (mbx0_wr) begin
            o_host_int_oe_n <= 1'b1;
        end else if (w_ctrl[32]) begin
            o_host_int_oe_n <= ~w_ctrl[etm_pkg::CTRL_HOST_INT_BIT];
        end
    end

    // data stand for the one cycle after the strobe, zero otherwise
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 32'h0;
            o_host_rdata <= 32'h0;
        end else begin
            o_rdata <= i_rd ? rd_mux(i_addr) : 32'h0;
            o_host_rdata <= i_host_rd ? rd_mux(i_host_addr) : 32'h0;
        end
    end

    etm_timer u_timer (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_presc(presc_reg),
        .i_count_wr(w_timer[32]),
        .i_count_wdata(w_timer[31:0]),
        .i_sched_wr(w_sched[32]),
        .i_sched_wdata(w_sched[31:0]),
        .o_count(count),
        .o_sched(sched),
        .o_fire(fire)
    );

    etm_prio u_prio (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_evt(evt_word),
        .o_idx(evt_idx),
        .o_valid(evt_valid)
    );

    sequence s_host_mbx0;
        i_host_wr && etm_pkg::is_mbx0(i_host_addr);
    endsequence
    sequence s_released;
        ##2 o_host_int_oe_n;
    endsequence

    a_mbx_cpu_set: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_wr && etm_pkg::is_mbx_hi(i_addr)) |=> mbx_evt_reg[$past(i_addr[7:3])])
        else $error("processor slot write did not set its event");
    a_mbx_host_set: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_host_wr && etm_pkg::is_mbx_hi(i_host_addr)) |-> ##2 mbx_evt_reg[$past(i_host_addr[7:3], 2)])
        else $error("host slot write did not set its event two cycles later");
    a_mbx0_release: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        s_host_mbx0 |-> s_released)
        else $error("host interrupt not released after first slot write");
    a_mbx_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (mbx_evt_reg[0] && !w_mbx[32]) |=> mbx_evt_reg[0])
        else $error("slot event dropped without a clear");
    a_plain_store: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_wr && etm_pkg::in_window(i_addr) && i_addr[9:8] != 2'h1 && !h_wr_reg && !w_mbx[32])
        |=> mbx_evt_reg == $past(mbx_evt_reg))
        else $error("plain window write changed slot events");
    a_soft_evt: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_wr && i_addr == etm_pkg::OFF_EVT) |=> soft_reg == $past(i_wdata[7:0]))
        else $error("software event bits not written");
    a_irq_level: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_irq == $past(|(irq_stat_reg & irq_mask_reg)))
        else $error("interrupt output does not follow masked status");
endmodule // etm_event_timer_mailbox
`default_nettype wire

//--- verif/etm_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module etm_host_model (
    // clock
    input wire logic i_clk,
    // host target port
    output var logic [11:0] o_addr,
    output var logic [31:0] o_wdata,
    output var logic o_wr,
    output var logic o_rd
);
    initial begin
        o_addr = 12'h000;
        o_wdata = 32'h0000_0000;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    // one strobe cycle; afterwards address and data flip so a stale value never looks valid
    task automatic cycle(input logic [11:0] a, input logic [31:0] d, input logic w);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= w;
        o_rd <= ~w;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_rd <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask
endmodule // etm_host_model
`default_nettype wire

//--- verif/etm_event_timer_mailbox_tb.sv
`timescale 1ns/100ps
`default_nettype none
module etm_event_timer_mailbox_tb;
    logic clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [11:0] i_addr = 12'h000;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [11:0] h_addr;
    logic [31:0] h_wdata;
    logic h_wr;
    logic h_rd;
    logic [31:0] o_rdata;
    logic [31:0] o_host_rdata;
    logic o_irq;
    logic o_host_int_o;
    logic o_host_int_oe_n;
    logic rd_p = 1'b0;
    logic rd_h = 1'b0;
    logic [31:0] qp[$];
    logic [31:0] qh[$];
    logic [31:0] d;
    logic [31:0] t0;
    logic [31:0] t1;
    logic [31:0] mbx;
    logic [11:0] plain[4] = '{12'h000, 12'h0fc, 12'h200, 12'h3fc};
    int k;
    int p;
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;

    always #10 clk = ~clk;

    etm_host_model u_host (
        .i_clk(clk),
        .o_addr(h_addr),
        .o_wdata(h_wdata),
        .o_wr(h_wr),
        .o_rd(h_rd)
    );

    etm_event_timer_mailbox u_dut (
        .i_clk(clk),
        .i_rst_n(i_rst_n),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_wr(i_wr),
        .i_rd(i_rd),
        .o_rdata(o_rdata),
        .i_host_addr(h_addr),
        .i_host_wdata(h_wdata),
        .i_host_wr(h_wr),
        .i_host_rd(h_rd),
        .o_host_rdata(o_host_rdata),
        .o_irq(o_irq),
        .o_host_int_o(o_host_int_o),
        .o_host_int_oe_n(o_host_int_oe_n)
    );

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic pcyc(input logic [11:0] a, input logic [31:0] dd, input logic w);
        @(posedge clk);
        i_addr <= a;
        i_wdata <= dd;
        i_wr <= w;
        i_rd <= ~w;
        @(posedge clk);
        i_wr <= 1'b0;
        i_rd <= 1'b0;
    endtask

    task automatic pw(input logic [11:0] a, input logic [31:0] dd);
        pcyc(a, dd, 1'b1);
    endtask

    task automatic pr(input logic [11:0] a, input logic [31:0] e);
        qp.push_back(e);
        pcyc(a, 32'h0, 1'b0);
    endtask

    task automatic hw(input logic [11:0] a, input logic [31:0] dd);
        u_host.cycle(a, dd, 1'b1);
    endtask

    task automatic hr(input logic [11:0] a, input logic [31:0] e);
        qh.push_back(e);
        u_host.cycle(a, 32'h0, 1'b0);
    endtask

    // captured reads bypass the queue so the value can feed later arithmetic
    task automatic pget(input logic [11:0] a, output logic [31:0] v);
        pcyc(a, 32'h0, 1'b0);
        @(negedge clk);
        v = o_rdata;
    endtask

    always @(posedge clk) begin
        rd_p <= i_rd;
        rd_h <= h_rd;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            summarize();
        end
    end

    // read data is looked at mid-cycle, one cycle after its strobe
    always @(negedge clk) begin
        if (rd_p && qp.size() > 0) check("proc rdata", o_rdata, qp.pop_front());
        else if (!rd_p) check("idle rdata", o_rdata, 32'h0);
        if (rd_h && qh.size() > 0) check("host rdata", o_host_rdata, qh.pop_front());
    end

    initial begin
        void'($urandom(32'h239651ed));
        repeat (10) @(posedge clk);
        check("int_oe_n", 32'(o_host_int_oe_n), 32'h1);
        check("int_o", 32'(o_host_int_o), 32'h0);
        check("irq", 32'(o_irq), 32'h0);
        i_rst_n <= 1'b1;
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            d = $urandom();
            if (i[0]) hw(plain[i], d);
            else pw(plain[i], d);
            pr(plain[i], d);
            hr(plain[i], d);
            pr(plain[i], d);
        end
        pr(etm_pkg::OFF_MBX_EVT, 32'h0);
        pr(etm_pkg::OFF_IRQ_STAT, 32'h0);
        pr(12'h4fc, 32'h0);
        $display("test window done");
        mbx = 32'h0;
        for (int i = 0; i < 7; i++) begin
            k = (i >= 5) ? 31 : 1 + $urandom_range(29);
            hw(12'h100 + 12'(k) * 12'h008, $urandom());
            pr(etm_pkg::OFF_MBX_EVT, mbx);
            d = $urandom();
            if (i[0]) hw(12'h104 + 12'(k) * 12'h008, d);
            else pw(12'h104 + 12'(k) * 12'h008, d);
            mbx[k] = 1'b1;
            pr(etm_pkg::OFF_MBX_EVT, mbx);
            hr(12'h104 + 12'(k) * 12'h008, d);
        end
        pr(etm_pkg::OFF_EVT, 32'h4000_0000);
        hr(etm_pkg::OFF_EVT_IDX, 32'h8000_001e);
        pr(etm_pkg::OFF_IRQ_STAT, 32'h2);
        pw(etm_pkg::OFF_MBX_EVT, mbx & 32'h7fff_ffff);
        pr(etm_pkg::OFF_MBX_EVT, 32'h8000_0000);
        pw(etm_pkg::OFF_MBX_EVT, 32'h8000_0000);
        pr(etm_pkg::OFF_MBX_EVT, 32'h0);
        pw(etm_pkg::OFF_IRQ_STAT, 32'h7);
        $display("test mailbox done");
        pw(etm_pkg::OFF_IRQ_MASK, 32'h4);
        pw(etm_pkg::OFF_CTRL, 32'h1);
        repeat (2) @(negedge clk);
        check("int_oe_n", 32'(o_host_int_oe_n), 32'h0);
        pr(etm_pkg::OFF_CTRL, 32'h1);
        hw(12'h100, $urandom());
        @(negedge clk);
        check("int_oe_n", 32'(o_host_int_oe_n), 32'h0);
        @(negedge clk);
        check("int_oe_n", 32'(o_host_int_oe_n), 32'h1);
        @(negedge clk);
        check("irq", 32'(o_irq), 32'h1);
        pr(etm_pkg::OFF_MBX_EVT, 32'h0);
        pw(etm_pkg::OFF_IRQ_STAT, 32'h7);
        repeat (2) @(negedge clk);
        check("irq", 32'(o_irq), 32'h0);
        $display("test host interrupt done");
        for (int b = 0; b < 8; b++) begin
            pw(etm_pkg::OFF_EVT, (32'h2 << b) - 32'h1);
            pr(etm_pkg::OFF_EVT, (32'h2 << b) - 32'h1);
            pr(etm_pkg::OFF_EVT_IDX, 32'h8000_0000 | 32'(b));
        end
        pw(etm_pkg::OFF_EVT_CLR, 32'h0000_00ff);
        pr(etm_pkg::OFF_EVT_IDX, 32'h0);
        pw(etm_pkg::OFF_EVT, 32'hffff_ff00);
        pr(etm_pkg::OFF_EVT, 32'h0);
        $display("test events done");
        for (int i = 0; i < 3; i++) begin
            p = (i == 0) ? 0 : (i == 1) ? 127 : $urandom_range(127);
            pw(etm_pkg::OFF_PRESC, 32'(p));
            pw(etm_pkg::OFF_TIMER, 32'hffff_ffff);
            pget(etm_pkg::OFF_TIMER, t0);
            repeat (2 * (p + 1) - 2) @(posedge clk);
            pget(etm_pkg::OFF_TIMER, t1);
            check("timer step", t1 - t0, 32'h2);
        end
        pw(etm_pkg::OFF_PRESC, 32'h0);
        pw(etm_pkg::OFF_IRQ_MASK, 32'h1);
        pget(etm_pkg::OFF_TIMER, t0);
        pw(etm_pkg::OFF_SCHED, t0 + 32'd40);
        pr(etm_pkg::OFF_EVT, 32'h0);
        repeat (40) @(posedge clk);
        pr(etm_pkg::OFF_EVT, 32'h8000_0000);
        @(negedge clk);
        check("irq", 32'(o_irq), 32'h1);
        for (int i = 0; i < 2; i++) begin
            pw(etm_pkg::OFF_EVT_CLR, 32'h8000_0000);
            pw(etm_pkg::OFF_IRQ_STAT, 32'h1);
            pget(etm_pkg::OFF_TIMER, t0);
            // late schedule inside the window fires, far outside it stays quiet
            pw(etm_pkg::OFF_SCHED, (i == 0) ? t0 - 32'h100 : t0 - etm_pkg::LATE_WIN - 32'h1000);
            repeat (4) @(posedge clk);
            pr(etm_pkg::OFF_EVT, (i == 0) ? 32'h8000_0000 : 32'h0);
        end
        $display("test timer done");
        summarize();
    end
endmodule // etm_event_timer_mailbox_tb
`default_nettype wire
